// File: gpio_pin_cell.sv
`default_nettype none
// one port bit: pin drive, pullup and read mux
module gpio_pin_cell (
  input wire logic latch_i,
  input wire logic dir_i,
  input wire logic pue_i,
  input wire logic pin_i,
  input wire logic ovr_i,
  input wire logic ovr_out_i,
  input wire logic ovr_oe_i,
  output logic out_o,
  output logic oe_n_o,
  output logic pu_o,
  output logic rd_o
);
  always_comb begin
    out_o = ovr_i ? ovr_out_i : latch_i;
    oe_n_o = ovr_i ? !ovr_oe_i : !dir_i;
    pu_o = pue_i && oe_n_o;
    rd_o = dir_i ? latch_i : pin_i;
  end
endmodule : gpio_pin_cell
`default_nettype wire

// File: gpio_pin_model.sv
`default_nettype none
// **********
// board pins: driven, pulled up, or floating to an outside level
// **********
module gpio_pin_model (
  input wire logic [14:0] out_i,
  input wire logic [14:0] oe_n_i,
  input wire logic [14:0] pu_i,
  input wire logic [14:0] ext_i,
  output logic [14:0] pin_o
);
  // a floating pin shows the outside level, which the bench keeps changing
  always_comb begin
    for (int i = 0; i < 15; i++) begin
      if (!oe_n_i[i]) begin
        pin_o[i] = out_i[i];
      end else if (pu_i[i]) begin
        pin_o[i] = 1'b1;
      end else begin
        pin_o[i] = ext_i[i];
      end
    end
  end
endmodule : gpio_pin_model
`default_nettype wire

// File: gpio_pkg.sv
`default_nettype none
package gpio_pkg;
  localparam int unsigned ADDR_W = 8;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_B_DATA = 8'h01;
  localparam logic [7:0] IDX_C_DATA = 8'h02;
  localparam logic [7:0] IDX_D_DATA = 8'h03;
  localparam logic [7:0] IDX_B_DIR = 8'h05;
  localparam logic [7:0] IDX_C_DIR = 8'h06;
  localparam logic [7:0] IDX_D_DIR = 8'h07;
  localparam logic [7:0] IDX_C_PUE = 8'h0c;
  localparam logic [7:0] IDX_D_PUE = 8'h0d;
  localparam logic [7:0] IDX_PERIPH = 8'h10;
  localparam logic [7:0] IDX_ADC_CH = 8'h11;
  localparam int unsigned B_W = 6;
  localparam int unsigned C_W = 2;
  localparam int unsigned D_W = 7;
  localparam logic [6:0] DIR_RESET = 7'h00;
  localparam logic [6:0] PUE_RESET = 7'h00;
  localparam logic [7:0] PERIPH_RESET = 8'h00;
  localparam logic [4:0] ADC_CH_RESET = 5'h1f;
  // periph control field positions
  localparam int unsigned P_SPI_EN = 0;
  localparam int unsigned P_SPI_MSTR = 1;
  localparam int unsigned P_T2C0_ELS = 2;
  localparam int unsigned P_T1C0_ELS = 4;
  localparam int unsigned P_T1C1_ELS = 6;
  // port d pin positions
  localparam int unsigned D_SS = 0;
  localparam int unsigned D_MISO = 1;
  localparam int unsigned D_MOSI = 2;
  localparam int unsigned D_SCK = 3;
  localparam int unsigned D_T1C0 = 4;
  localparam int unsigned D_T1C1 = 5;
  localparam int unsigned D_T2C0 = 6;

  typedef struct packed {
    logic [5:0] b_data;
    logic [5:0] b_dir;
    logic [1:0] c_data;
    logic [1:0] c_dir;
    logic [1:0] c_pue;
    logic [6:0] d_data;
    logic [6:0] d_dir;
    logic [6:0] d_pue;
    logic [7:0] periph;
    logic [4:0] adc_ch;
  } gpio_regs_t;

  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe_n;
    logic [6:0] pu;
  } gpio_pins_t;
endpackage : gpio_pkg
`default_nettype wire

// File: gpio_ports.sv
// The APB slave port is this design's own decision.
`default_nettype none
// **********
// **********
module gpio_ports (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [5:0] b_pin_i,
  output logic [5:0] b_out_o,
  output logic [5:0] b_oe_n_o,
  output logic [5:0] analog_input_pins_o,
  input wire logic [1:0] c_pin_i,
  output logic [1:0] c_out_o,
  output logic [1:0] c_oe_n_o,
  output logic [1:0] c_pu_o,
  input wire logic [6:0] d_pin_i,
  output gpio_pkg::gpio_pins_t d_pins_o,
  input wire logic spi_sck_out_i,
  input wire logic spi_mosi_out_i,
  input wire logic spi_miso_out_i,
  output logic spi_ss_n_o,
  input wire logic [2:0] timer_ch_out_i,
  input wire logic [2:0] timer_ch_oe_i,
  output logic [2:0] timer_ch_in_o
);
  // **********
  // state
  // **********
  typedef struct packed {
    gpio_pkg::gpio_regs_t regs;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [5:0] b_out;
    logic [5:0] b_oe_n;
    logic [5:0] b_ana;
    logic [1:0] c_out;
    logic [1:0] c_oe_n;
    logic [1:0] c_pu;
    gpio_pkg::gpio_pins_t d_pins;
    logic ss_n;
    logic [2:0] tin;
  } gpio_state_t;

  gpio_state_t st;
  gpio_state_t next_st;

  logic [5:0] b_out_w, b_oen_w, b_pu_w, b_rd;
  logic [1:0] c_out_w, c_oen_w, c_pu_w, c_rd;
  logic [6:0] d_out_w, d_oen_w, d_pu_w, d_rd;
  logic [6:0] d_ovr, d_ovr_out, d_ovr_oe;
  logic [5:0] b_ana_sel;
  logic spi_en, spi_slave;

  // **********
  // peripheral overrides
  // **********
  always_comb begin
    spi_en = st.regs.periph[gpio_pkg::P_SPI_EN];
    spi_slave = spi_en && !st.regs.periph[gpio_pkg::P_SPI_MSTR];
    d_ovr = '0;
    d_ovr_out = '0;
    d_ovr_oe = '0;
    d_ovr[gpio_pkg::D_SS] = spi_slave;
    d_ovr[gpio_pkg::D_MISO] = spi_en;
    d_ovr_out[gpio_pkg::D_MISO] = spi_miso_out_i;
    d_ovr_oe[gpio_pkg::D_MISO] = spi_slave;
    d_ovr[gpio_pkg::D_MOSI] = spi_en;
    d_ovr_out[gpio_pkg::D_MOSI] = spi_mosi_out_i;
    d_ovr_oe[gpio_pkg::D_MOSI] = !spi_slave;
    d_ovr[gpio_pkg::D_SCK] = spi_en;
    d_ovr_out[gpio_pkg::D_SCK] = spi_sck_out_i;
    d_ovr_oe[gpio_pkg::D_SCK] = !spi_slave;
    // timer channel owns pin when its edge/level select is nonzero
    d_ovr[gpio_pkg::D_T1C0] = |st.regs.periph[gpio_pkg::P_T1C0_ELS +: 2];
    d_ovr[gpio_pkg::D_T1C1] = |st.regs.periph[gpio_pkg::P_T1C1_ELS +: 2];
    d_ovr[gpio_pkg::D_T2C0] = |st.regs.periph[gpio_pkg::P_T2C0_ELS +: 2];
    d_ovr_out[6:4] = {timer_ch_out_i[2], timer_ch_out_i[1], timer_ch_out_i[0]};
    d_ovr_oe[6:4] = {timer_ch_oe_i[2], timer_ch_oe_i[1], timer_ch_oe_i[0]};
    for (int i = 0; i < 6; i++) begin
      b_ana_sel[i] = (st.regs.adc_ch == 5'(i));
    end
  end

  // **********
  // pin cells
  // **********
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_b
      gpio_pin_cell u_cell (
        .latch_i(st.regs.b_data[g]),
        .dir_i(st.regs.b_dir[g]),
        .pue_i(1'b0),
        .pin_i(b_pin_i[g]),
        .ovr_i(b_ana_sel[g]),
        .ovr_out_i(1'b0),
        .ovr_oe_i(1'b0),
        .out_o(b_out_w[g]),
        .oe_n_o(b_oen_w[g]),
        .pu_o(b_pu_w[g]),
        .rd_o(b_rd[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_c
      gpio_pin_cell u_cell (
        .latch_i(st.regs.c_data[g]),
        .dir_i(st.regs.c_dir[g]),
        .pue_i(st.regs.c_pue[g]),
        .pin_i(c_pin_i[g]),
        .ovr_i(1'b0),
        .ovr_out_i(1'b0),
        .ovr_oe_i(1'b0),
        .out_o(c_out_w[g]),
        .oe_n_o(c_oen_w[g]),
        .pu_o(c_pu_w[g]),
        .rd_o(c_rd[g])
      );
    end
    for (g = 0; g < 7; g++) begin : g_d
      gpio_pin_cell u_cell (
        .latch_i(st.regs.d_data[g]),
        .dir_i(st.regs.d_dir[g]),
        .pue_i(st.regs.d_pue[g]),
        .pin_i(d_pin_i[g]),
        .ovr_i(d_ovr[g]),
        .ovr_out_i(d_ovr_out[g]),
        .ovr_oe_i(d_ovr_oe[g]),
        .out_o(d_out_w[g]),
        .oe_n_o(d_oen_w[g]),
        .pu_o(d_pu_w[g]),
        .rd_o(d_rd[g])
      );
    end
  endgenerate

  // **********
  // apb slave and register update
  // **********
  logic access, wr, rd;
  logic [7:0] idx;
  logic hit;
  logic [7:0] wb;
  logic [31:0] rdv;

  always_comb begin
    next_st = st;
    access = psel_i && penable_i && !st.ready;
    // write lands on the edge where the master sees pready high, never earlier
    wr = psel_i && penable_i && pwrite_i && st.ready;
    rd = access && !pwrite_i;
    idx = paddr_i[9:2];
    wb = pwdata_i[7:0];
    hit = 1'b1;
    rdv = '0;
    case (idx)
      gpio_pkg::IDX_B_DATA: rdv[5:0] = b_rd;
      gpio_pkg::IDX_C_DATA: rdv[1:0] = c_rd;
      gpio_pkg::IDX_D_DATA: rdv[6:0] = d_rd;
      gpio_pkg::IDX_B_DIR: rdv[5:0] = st.regs.b_dir;
      gpio_pkg::IDX_C_DIR: rdv[1:0] = st.regs.c_dir;
      gpio_pkg::IDX_D_DIR: rdv[6:0] = st.regs.d_dir;
      gpio_pkg::IDX_C_PUE: rdv[1:0] = st.regs.c_pue;
      gpio_pkg::IDX_D_PUE: rdv[6:0] = st.regs.d_pue;
      gpio_pkg::IDX_PERIPH: rdv[7:0] = st.regs.periph;
      gpio_pkg::IDX_ADC_CH: rdv[4:0] = st.regs.adc_ch;
      default: hit = 1'b0;
    endcase
    if (wr) begin
      case (idx)
        gpio_pkg::IDX_B_DATA: next_st.regs.b_data = wb[5:0];
        gpio_pkg::IDX_C_DATA: next_st.regs.c_data = wb[1:0];
        gpio_pkg::IDX_D_DATA: next_st.regs.d_data = wb[6:0];
        gpio_pkg::IDX_B_DIR: next_st.regs.b_dir = wb[5:0];
        gpio_pkg::IDX_C_DIR: next_st.regs.c_dir = wb[1:0];
        gpio_pkg::IDX_D_DIR: next_st.regs.d_dir = wb[6:0];
        gpio_pkg::IDX_C_PUE: next_st.regs.c_pue = wb[1:0];
        gpio_pkg::IDX_D_PUE: next_st.regs.d_pue = wb[6:0];
        gpio_pkg::IDX_PERIPH: next_st.regs.periph = wb;
        gpio_pkg::IDX_ADC_CH: next_st.regs.adc_ch = wb[4:0];
        default: ;
      endcase
    end
    // one wait state keeps prdata registered; ready pulses one cycle
    next_st.ready = access;
    next_st.err = access && !hit;
    if (rd) begin
      next_st.rdata = rdv;
    end
    next_st.b_out = b_out_w;
    next_st.b_oe_n = b_oen_w;
    next_st.b_ana = b_ana_sel;
    next_st.c_out = c_out_w;
    next_st.c_oe_n = c_oen_w;
    next_st.c_pu = c_pu_w;
    next_st.d_pins.out = d_out_w;
    next_st.d_pins.oe_n = d_oen_w;
    next_st.d_pins.pu = d_pu_w;
    // slave select reads high (idle) unless the spi owns the pin
    next_st.ss_n = spi_slave ? d_pin_i[gpio_pkg::D_SS] : 1'b1;
    next_st.tin = d_pin_i[6:4];
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // data latches have no reset in hardware; zero here keeps sim free of x
      st <= '0;
      st.regs.b_dir <= gpio_pkg::DIR_RESET[5:0];
      st.regs.c_dir <= gpio_pkg::DIR_RESET[1:0];
      st.regs.d_dir <= gpio_pkg::DIR_RESET;
      st.regs.c_pue <= gpio_pkg::PUE_RESET[1:0];
      st.regs.d_pue <= gpio_pkg::PUE_RESET;
      st.regs.periph <= gpio_pkg::PERIPH_RESET;
      st.regs.adc_ch <= gpio_pkg::ADC_CH_RESET;
      st.b_oe_n <= 6'h3f;
      st.c_oe_n <= 2'h3;
      st.d_pins.oe_n <= 7'h7f;
      st.ss_n <= 1'b1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign prdata_o = st.rdata;
  assign pready_o = st.ready;
  assign pslverr_o = st.err;
  assign b_out_o = st.b_out;
  assign b_oe_n_o = st.b_oe_n;
  assign analog_input_pins_o = st.b_ana;
  assign c_out_o = st.c_out;
  assign c_oe_n_o = st.c_oe_n;
  assign c_pu_o = st.c_pu;
  assign d_pins_o = st.d_pins;
  assign spi_ss_n_o = st.ss_n;
  assign timer_ch_in_o = st.tin;
endmodule : gpio_ports
`default_nettype wire

// File: gpio_ports_chk.sv
`default_nettype none
// **********
// bus timing and pin safety checks
// **********
module gpio_ports_chk (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [5:0] b_oe_n_o,
  input wire logic [5:0] analog_input_pins_o,
  input wire logic [1:0] c_oe_n_o,
  input wire logic [1:0] c_pu_o,
  input wire logic [6:0] d_pin_i,
  input wire gpio_pkg::gpio_pins_t d_pins_o,
  input wire logic spi_ss_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held too long");
  ready_answer_a: assert property (psel_i && penable_i && ce_i && !pready_o |=> pready_o)
    else $error("ready late");
  err_read_a: assert property (pslverr_o |-> pready_o && (pwrite_i || prdata_o == 32'h0))
    else $error("bad refused access");
  c_pull_a: assert property ((c_pu_o & ~c_oe_n_o) == 2'h0) else $error("port c pullup on output");
  d_pull_a: assert property ((d_pins_o.pu & ~d_pins_o.oe_n) == 7'h00)
    else $error("port d pullup on output");
  adc_force_a: assert property ($onehot0(analog_input_pins_o) && (analog_input_pins_o & ~b_oe_n_o) == 6'h00)
    else $error("analog pin still driven");
  reset_dir_a: assert property ($rose(reset_n_i) |-> b_oe_n_o == 6'h3f && c_oe_n_o == 2'h3 && d_pins_o.oe_n == 7'h7f)
    else $error("pins not inputs after reset");
  ss_follow_a: assert property (!spi_ss_n_o |-> $past(d_pin_i[0]) == 1'b0) else $error("select not from pin");
  c_pull_on_a: assert property (c_pu_o != 2'h0 |-> $past(c_oe_n_o & c_pu_o) != 2'h0 || $past(c_pu_o) == 2'h0)
    else $error("port c pullup wrong");
  cover property (pslverr_o);
  cover property (analog_input_pins_o != 6'h00);
  cover property (!spi_ss_n_o);
endmodule : gpio_ports_chk
bind gpio_ports gpio_ports_chk chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .b_oe_n_o(b_oe_n_o), .analog_input_pins_o(analog_input_pins_o), .c_oe_n_o(c_oe_n_o), .c_pu_o(c_pu_o),
  .d_pin_i(d_pin_i), .d_pins_o(d_pins_o), .spi_ss_n_o(spi_ss_n_o));
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_n_i, psel, penable, pwrite, sck, mosi, miso;
  logic [9:0] paddr;
  logic [31:0] pwdata, r;
  logic [31:0] cyc = 32'h0;
  logic ce;
  logic [14:0] ext;
  logic [2:0] tout, toe;
  logic [7:0] m, e, dir;
  logic [32:0] q[$];
  int err_count, num_checks;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, ss_n;
  wire logic [5:0] b_out, b_oe_n, analog;
  wire logic [1:0] c_out, c_oe_n, c_pu;
  wire logic [14:0] pins;
  wire logic [2:0] tin;
  wire gpio_pkg::gpio_pins_t dp;
  gpio_ports uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .b_pin_i(pins[5:0]), .b_out_o(b_out), .b_oe_n_o(b_oe_n), .analog_input_pins_o(analog),
    .c_pin_i(pins[7:6]), .c_out_o(c_out), .c_oe_n_o(c_oe_n), .c_pu_o(c_pu), .d_pin_i(pins[14:8]), .d_pins_o(dp),
    .spi_sck_out_i(sck), .spi_mosi_out_i(mosi), .spi_miso_out_i(miso), .spi_ss_n_o(ss_n),
    .timer_ch_out_i(tout), .timer_ch_oe_i(toe), .timer_ch_in_o(tin));
  gpio_pin_model pm (.out_i({dp.out, c_out, b_out}), .oe_n_i({dp.oe_n, c_oe_n, b_oe_n}),
    .pu_i({dp.pu, c_pu, 6'h00}), .ext_i(ext), .pin_o(pins));
  // **********
  // helpers
  // **********
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one idle cycle after each transfer so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic rd(input logic [7:0] idx, input logic [7:0] x, input logic err);
    q.push_back({err, 24'h0, x});
    apb(1'b0, idx, 8'h00);
  endtask : rd
  task automatic dcase(input logic [7:0] per, input logic [7:0] d, input logic [7:0] x);
    apb(1'b1, gpio_pkg::IDX_PERIPH, per);
    apb(1'b1, gpio_pkg::IDX_D_DIR, d);
    repeat (4) @(posedge clk_i);
    rd(gpio_pkg::IDX_D_DATA, x, 1'b0);
  endtask : dcase
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // **********
  // clock, result watcher, hang guard
  // **********
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (pready === 1'b1 && pwrite === 1'b0 && q.size() > 0) begin
      chk({pslverr, prdata}, q.pop_front());
    end
    cyc <= cyc + 32'h1;
    if (cyc == 32'd20000) begin
      err_count++;
      give_verdict();
    end
  end
  // **********
  // scenarios
  // **********
  initial begin
    {reset_n_i, psel, penable, pwrite, sck, mosi, miso, paddr, pwdata, ext, tout, toe} = '0;
    ce = 1'b1;
    r = 32'h1657a67b;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(gpio_pkg::IDX_B_DIR, 8'h00, 1'b0);
    rd(gpio_pkg::IDX_C_DIR, 8'h00, 1'b0);
    rd(gpio_pkg::IDX_D_DIR, 8'h00, 1'b0);
    rd(8'h08, 8'h00, 1'b1);
    for (int n = 0; n < 60; n++) begin
      r = lfsr(r);
      m = (n % 3 == 0) ? 8'h3f : (n % 3 == 1) ? 8'h03 : 8'h7f;
      dir = r[15:8] & m;
      // data goes in before direction so a new output starts clean
      apb(1'b1, gpio_pkg::IDX_B_DATA + 8'(n % 3), r[7:0] & m);
      apb(1'b1, gpio_pkg::IDX_B_DIR + 8'(n % 3), dir);
      ext <= r[30:16];
      repeat (4) @(posedge clk_i);
      e = (n % 3 == 0) ? {2'b0, r[21:16]} : (n % 3 == 1) ? {6'b0, r[23:22]} : {1'b0, r[30:24]};
      rd(gpio_pkg::IDX_B_DATA + 8'(n % 3), (dir & r[7:0]) | (~dir & e & m), 1'b0);
      if (n % 3 == 0) chk({21'h0, b_out & ~b_oe_n, b_oe_n}, {21'h0, dir[5:0] & r[5:0], ~dir[5:0]});
    end
    ext <= 15'h0;
    apb(1'b1, gpio_pkg::IDX_C_DIR, 8'h00);
    apb(1'b1, gpio_pkg::IDX_C_PUE, 8'h03);
    apb(1'b1, gpio_pkg::IDX_D_PUE, 8'h7f);
    dcase(8'h00, 8'h00, 8'h7f);
    rd(gpio_pkg::IDX_C_DATA, 8'h03, 1'b0);
    apb(1'b1, gpio_pkg::IDX_C_DIR, 8'h01);
    @(posedge clk_i);
    chk({31'h0, c_pu}, {31'h0, 2'b10});
    apb(1'b1, gpio_pkg::IDX_D_PUE, 8'h00);
    apb(1'b1, gpio_pkg::IDX_D_DATA, 8'h55);
    sck <= 1'b1;
    miso <= 1'b1;
    dcase(8'h03, 8'h00, 8'h08);
    dcase(8'h03, 8'h7f, 8'h55);
    dcase(8'h01, 8'h00, 8'h02);
    chk({32'h0, ss_n}, 33'h0);
    dcase(8'h00, 8'h00, 8'h00);
    chk({32'h0, ss_n}, 33'h1);
    tout <= 3'b111;
    toe <= 3'b111;
    dcase(8'h04, 8'h00, 8'h40);
    dcase(8'h50, 8'h00, 8'h30);
    apb(1'b1, gpio_pkg::IDX_B_DATA, 8'h3f);
    apb(1'b1, gpio_pkg::IDX_B_DIR, 8'h3f);
    apb(1'b1, gpio_pkg::IDX_ADC_CH, 8'h02);
    @(posedge clk_i);
    chk({21'h0, analog, b_oe_n}, {21'h0, 6'h04, 6'h04});
    rd(gpio_pkg::IDX_B_DATA, 8'h3f, 1'b0);
    // timer inputs follow the pins, and freeze while the clock enable is low
    apb(1'b1, gpio_pkg::IDX_PERIPH, 8'h00);
    ext <= 15'h7000;
    repeat (3) @(posedge clk_i);
    chk({30'h0, tin}, {30'h0, 3'b111});
    ce <= 1'b0;
    ext <= 15'h0;
    repeat (3) @(posedge clk_i);
    chk({30'h0, tin}, {30'h0, 3'b111});
    ce <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({30'h0, tin}, 33'h0);
    repeat (4) @(posedge clk_i);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
